// ==== inc/dual_access_pkg.sv ====
// constants and types for the dual access drive reservation block
// assumes a single 100 MHz clock shared by every design file
package dual_access_pkg;

    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;

    // release pulse on the seek end line
    localparam int unsigned RELEASE_PULSE_NS = 30_000;
    localparam int unsigned PULSE_CYCLES     = RELEASE_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_W          = 12;

    // reserve timer after the holder drops its select
    localparam int unsigned RESERVE_MS       = 500;
    localparam int unsigned RESERVE_CYCLES   = RESERVE_MS * (CLK_HZ / 1000);
    localparam int unsigned RESERVE_W        = 26;

    // bit positions of the pin inputs inside the synchroniser
    localparam int unsigned PIN_SEL_A        = 0;
    localparam int unsigned PIN_BUS9_A       = 1;
    localparam int unsigned PIN_TAG3_A       = 2;
    localparam int unsigned PIN_SEL_B        = 3;
    localparam int unsigned PIN_BUS9_B       = 4;
    localparam int unsigned PIN_TAG3_B       = 5;
    localparam int unsigned PIN_EN_A         = 6;
    localparam int unsigned PIN_EN_B         = 7;
    localparam int unsigned PIN_TIMER_EN     = 8;
    localparam int unsigned PIN_POWER_SEQ    = 9;
    localparam int unsigned PIN_COUNT        = 10;

    localparam logic [PIN_COUNT-1:0] PIN_RESET = 10'h000;

    typedef enum logic [1:0] {
        s_free    = 2'b00,
        s_hold_a  = 2'b01,
        s_release = 2'b11,
        s_hold_b  = 2'b10
    } arb_state_t;

endpackage : dual_access_pkg

// ==== hw/pin_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pin levels
// assumes the inputs are static levels, not pulses shorter than a clock
module pin_sync
    import dual_access_pkg::*;
#(
    parameter int unsigned WIDTH = PIN_COUNT
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : pin_sync

// ==== hw/hold_timer.sv ====
// reloadable down counter: done is high once LEN-1 cycles passed without load
// assumes load is held while the timed interval must not run
module hold_timer #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned LEN   = 16
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic load,
    output logic      done
);

    localparam logic [WIDTH-1:0] START = WIDTH'(LEN - 1);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        if (load) begin
            next_count = START;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= START;
        end else begin
            count <= next_count;
        end
    end

    assign done = (count == '0) && !load;

endmodule : hold_timer

// ==== hw/dual_access_arbiter.sv ====
// dual access arbiter: grants one drive to controller port a or b
// assumes all port pins are asynchronous levels and one 100 MHz clock
//
// Contract
// (R1) at most one port holds the drive at any moment
// (R2) selecting reserves the drive; the alternate port's select is refused
// (R3) the waiting port sees busy while the drive is held
// (R4) release gives one 30 us seek end pulse, then either port may select
// (R5) simultaneous selects from a and b grant port a
// (R6) the holding controller keeps its select tag up during operations
// (R7) a power up or down sequence clears any reservation
// (R8) online, a reservation ends by reserve timer expiry or release command
// (R9) with timer strap, reservation lasts 0.5 s after deselect unless reselected
// (R10) bus 9 at select rising edge gives priority reserve unless other holds
// (R11) priority ignores the timer until release: bus 9 with tag 3
// (R12) per-port enables; selection on a disabled port is ignored
// (R13) timer and pulse lengths are clock counts derived from the clock rate
module dual_access_arbiter
    import dual_access_pkg::*;
#(
    parameter int unsigned RESERVE_LEN = RESERVE_CYCLES
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic sel_a,
    input  wire logic bus9_a,
    input  wire logic tag3_a,
    input  wire logic sel_b,
    input  wire logic bus9_b,
    input  wire logic tag3_b,
    input  wire logic enable_a,
    input  wire logic enable_b,
    input  wire logic timer_enable,
    input  wire logic power_seq,
    output logic      drive_a,
    output logic      drive_b,
    output logic      busy_a,
    output logic      busy_b,
    output logic      reserved_a,
    output logic      reserved_b,
    output logic      priority_held,
    output logic      seek_end
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [PIN_COUNT-1:0] pins;
    logic                 ea;
    logic                 eb;
    logic                 sa;
    logic                 sb;
    logic                 prev_sa;
    logic                 prev_sb;
    logic                 rise_a;
    logic                 rise_b;
    logic                 rel_a;
    logic                 rel_b;

    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     ({power_seq, timer_enable, enable_b, enable_a,
                 tag3_b, bus9_b, sel_b, tag3_a, bus9_a, sel_a}),
        .q     (pins)
    );

    assign ea     = pins[PIN_EN_A];
    assign eb     = pins[PIN_EN_B];
    assign sa     = pins[PIN_SEL_A] && ea; // R12
    assign sb     = pins[PIN_SEL_B] && eb; // R12
    assign rise_a = sa && !prev_sa;
    assign rise_b = sb && !prev_sb;
    assign rel_a  = sa && pins[PIN_BUS9_A] && pins[PIN_TAG3_A];
    assign rel_b  = sb && pins[PIN_BUS9_B] && pins[PIN_TAG3_B];

    ////////////////////////////////////////////////////////////////////////////
    // timers

    arb_state_t state;
    arb_state_t next_state;
    logic       hold_sel;
    logic       rsv_done;
    logic       pulse_done;

    assign hold_sel = (state == s_hold_a) ? sa : (state == s_hold_b) ? sb : 1'b1;

    // reserve timer reloads while the holder keeps its select up
    hold_timer #(
        .WIDTH (RESERVE_W),
        .LEN   (RESERVE_LEN)
    ) u_reserve ( // R13
        .clock (clock),
        .nrst  (nrst),
        .load  (hold_sel),
        .done  (rsv_done)
    );

    hold_timer #(
        .WIDTH (PULSE_W),
        .LEN   (PULSE_CYCLES)
    ) u_pulse ( // R13
        .clock (clock),
        .nrst  (nrst),
        .load  (state != s_release),
        .done  (pulse_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // arbitration state

    logic prio;
    logic next_prio;
    logic ends_hold;

    always_comb begin
        next_state = state;
        next_prio  = prio;
        ends_hold  = 1'b0;
        unique case (state)
            s_free: begin
                if (sa) begin // R5
                    next_state = s_hold_a; // R2
                    next_prio  = rise_a && pins[PIN_BUS9_A]; // R10
                end else if (sb) begin
                    next_state = s_hold_b; // R2
                    next_prio  = rise_b && pins[PIN_BUS9_B]; // R10
                end
            end
            s_hold_a, s_hold_b: begin
                if (state == s_hold_a) begin
                    ends_hold = rel_a; // R8 R11
                    if (rise_a && pins[PIN_BUS9_A]) begin
                        next_prio = 1'b1; // R10
                    end
                end else begin
                    ends_hold = rel_b; // R8 R11
                    if (rise_b && pins[PIN_BUS9_B]) begin
                        next_prio = 1'b1; // R10
                    end
                end
                if (!prio && !hold_sel && (!pins[PIN_TIMER_EN] || rsv_done)) begin
                    ends_hold = 1'b1; // R9 R8
                end
                if (ends_hold) begin
                    next_state = s_release; // R4
                    next_prio  = 1'b0;
                end
            end
            s_release: begin
                if (pulse_done) begin
                    next_state = s_free; // R4
                end
            end
        endcase
        if (pins[PIN_POWER_SEQ]) begin
            next_state = s_free; // R7
            next_prio  = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state   <= s_free;
            prio    <= 1'b0;
            prev_sa <= 1'b0;
            prev_sb <= 1'b0;
        end else begin
            state   <= next_state;
            prio    <= next_prio;
            prev_sa <= sa;
            prev_sb <= sb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic next_drive_a;
    logic next_drive_b;
    logic next_busy_a;
    logic next_busy_b;

    always_comb begin
        next_drive_a = (next_state == s_hold_a) && sa; // R1
        next_drive_b = (next_state == s_hold_b) && sb; // R1
        next_busy_a  = sa && (next_state == s_hold_b || next_state == s_release); // R3
        next_busy_b  = sb && (next_state == s_hold_a || next_state == s_release); // R3
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_a       <= 1'b0;
            drive_b       <= 1'b0;
            busy_a        <= 1'b0;
            busy_b        <= 1'b0;
            reserved_a    <= 1'b0;
            reserved_b    <= 1'b0;
            priority_held <= 1'b0;
            seek_end      <= 1'b0;
        end else begin
            drive_a       <= next_drive_a;
            drive_b       <= next_drive_b;
            busy_a        <= next_busy_a;
            busy_b        <= next_busy_b;
            reserved_a    <= next_state == s_hold_a;
            reserved_b    <= next_state == s_hold_b;
            priority_held <= next_prio;
            seek_end      <= next_state == s_release; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [PULSE_W-1:0] high_cnt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            high_cnt <= '0;
        end else if (seek_end) begin
            high_cnt <= high_cnt + 1'b1;
        end else begin
            high_cnt <= '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    one_holder_a: assert property (!(drive_a && drive_b) && !(reserved_a && reserved_b)) // R1
        else $error("drive held by both ports");

    refuse_alt_a: assert property (reserved_a && sb && !power_seq |=> !drive_b) // R2
        else $error("alternate port got the drive");

    busy_wait_a: assert property (reserved_a && sb && !pins[PIN_POWER_SEQ] && state == s_hold_a
                                  && next_state == s_hold_a |=> busy_b) // R3
        else $error("waiting port not busy");

    pulse_width_a: assert property ($fell(seek_end) |-> high_cnt == PULSE_W'(PULSE_CYCLES)
                                    || $past(pins[PIN_POWER_SEQ])) // R4
        else $error("seek end pulse has wrong width");

    tie_goes_a_a: assert property (state == s_free && sa && sb && !pins[PIN_POWER_SEQ]
                                   |=> reserved_a ##0 busy_b) // R5
        else $error("simultaneous select not granted to a");

    power_clear_a: assert property (pins[PIN_POWER_SEQ] |=> !reserved_a && !reserved_b
                                    && !priority_held && !seek_end) // R7
        else $error("power sequence left a reservation");

    release_cmd_a: assert property (state == s_hold_a && rel_a && !pins[PIN_POWER_SEQ]
                                    |=> seek_end && !reserved_a) // R8 R11
        else $error("release command ignored");

    prio_holds_a: assert property (priority_held && reserved_a && !rel_a && !pins[PIN_POWER_SEQ]
                                   |=> reserved_a) // R11 R9
        else $error("priority reservation dropped without release");

    no_strap_a: assert property (state == s_hold_b && !prio && !sb && !pins[PIN_TIMER_EN]
                                 && !pins[PIN_POWER_SEQ] |=> seek_end) // R9
        else $error("deselect without timer did not release");

    disabled_a: assert property (!ea |-> ##1 !drive_a && !busy_a) // R12
        else $error("disabled port a served");

    prio_edge_a: assert property (state == s_free && rise_a && pins[PIN_BUS9_A]
                                  && !pins[PIN_POWER_SEQ] |=> priority_held) // R10
        else $error("priority select not taken");

    busy_wait_b_a: assert property (reserved_b && sa && !pins[PIN_POWER_SEQ] && state == s_hold_b
                                    && next_state == s_hold_b |=> busy_a) // R3
        else $error("waiting port a not busy");

    release_b_a: assert property (state == s_hold_b && rel_b && !pins[PIN_POWER_SEQ]
                                  |=> seek_end && !reserved_b) // R8 R11
        else $error("release command on port b ignored");

    timer_keep_a: assert property (state == s_hold_a && !sa && pins[PIN_TIMER_EN] && !rsv_done
                                   && !pins[PIN_POWER_SEQ] |=> reserved_a) // R9
        else $error("reservation dropped before the reserve timer ran out");

    timer_expiry_a: assert property (state == s_hold_a && !prio && !sa && pins[PIN_TIMER_EN] && rsv_done
                                     && !pins[PIN_POWER_SEQ] |=> seek_end && !reserved_a) // R9 R8
        else $error("reserve timer expiry did not release");

    no_preempt_a: assert property (state == s_hold_a && rise_b && pins[PIN_BUS9_B]
                                   && !pins[PIN_POWER_SEQ] |=> !reserved_b) // R10
        else $error("priority select took a drive held by the other port");

    disabled_b_a: assert property (!eb |-> ##1 !drive_b && !busy_b) // R12
        else $error("disabled port b served");

    grant_b_c: cover property (state == s_free && sb && !sa ##1 reserved_b);
    release_c: cover property ($fell(seek_end) ##1 state == s_free);
    priority_c: cover property (priority_held && rel_a ##1 seek_end);
    timeout_c: cover property (state == s_hold_a && rsv_done && !sa ##1 seek_end);
    release_b_c: cover property (state == s_hold_b && rel_b ##1 seek_end);

endmodule : dual_access_arbiter

// ==== tb/ctl_model.sv ====
// controller model driving one access port: select tag, bus bit 9, control tag 3
// assumes one caller at a time; pins change 1 ns after a rising clock edge
module ctl_model (
    input  wire logic clock,
    output logic      sel,
    output logic      bus9,
    output logic      tag3
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sel  = 1'b0;
        bus9 = 1'b0;
        tag3 = 1'b0;
    end

    task automatic step(input logic s, input logic b, input logic t);
        @(posedge clock);
        #1;
        sel  = s;
        bus9 = b;
        tag3 = t;
    endtask : step

    // select stays up until drop or release_cmd lowers it: the holder never lets it sag mid operation
    task automatic pick(input logic prio);
        if (prio) begin
            step(1'b0, 1'b1, 1'b0);
        end
        step(1'b1, prio, 1'b0);
        repeat (4) @(posedge clock);
        step(1'b1, 1'b0, 1'b0);
    endtask : pick

    task automatic drop();
        step(1'b0, 1'b0, 1'b0);
    endtask : drop

    // release command needs the holder's select up together with bus 9 and tag 3
    task automatic release_cmd();
        step(1'b1, 1'b1, 1'b1);
        repeat (4) @(posedge clock);
        step(1'b0, 1'b0, 1'b0);
    endtask : release_cmd

endmodule : ctl_model

// ==== tb/dual_port_drive_reservation_tb.sv ====
// self-checking bench for the dual access arbiter with two controller models
// assumes the package constants and a 100 MHz clock; reserve timer shortened
module dual_port_drive_reservation_tb
    import dual_access_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned RLEN  = 20;
    localparam int unsigned LIMIT = 40000;

    logic clock;
    logic nrst;
    logic enable_a;
    logic enable_b;
    logic timer_enable;
    logic power_seq;
    logic sel_a, bus9_a, tag3_a, sel_b, bus9_b, tag3_b;
    logic drive_a, drive_b, busy_a, busy_b, reserved_a, reserved_b, priority_held, seek_end;
    int   n_mismatch = 0;
    int   compares   = 0;
    int   cycles     = 0;

    ctl_model u_ctl_a (.clock(clock), .sel(sel_a), .bus9(bus9_a), .tag3(tag3_a));
    ctl_model u_ctl_b (.clock(clock), .sel(sel_b), .bus9(bus9_b), .tag3(tag3_b));

    dual_access_arbiter #(.RESERVE_LEN(RLEN)) u_dut (
        .clock(clock), .nrst(nrst), .sel_a(sel_a), .bus9_a(bus9_a), .tag3_a(tag3_a),
        .sel_b(sel_b), .bus9_b(bus9_b), .tag3_b(tag3_b), .enable_a(enable_a),
        .enable_b(enable_b), .timer_enable(timer_enable), .power_seq(power_seq),
        .drive_a(drive_a), .drive_b(drive_b), .busy_a(busy_a), .busy_b(busy_b),
        .reserved_a(reserved_a), .reserved_b(reserved_b),
        .priority_held(priority_held), .seek_end(seek_end));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc

    // waits for the release pulse and measures its width in cycles
    task automatic pulse_check(input int limit);
        int n;
        n = 0;
        while (seek_end !== 1'b1 && n < limit) begin
            wait_cyc(1);
            n++;
        end
        check(seek_end, 1'b1);
        n = 0;
        while (seek_end === 1'b1 && n < 4000) begin
            wait_cyc(1);
            n++;
        end
        check(n, PULSE_CYCLES);
    endtask : pulse_check

    always @(negedge clock) begin
        if (nrst === 1'b1) begin
            check(drive_a & drive_b, 1'b0);
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_grant();
        u_ctl_a.pick(1'b0);
        wait_cyc(4);
        check({reserved_a, drive_a, drive_b}, 3'h6);
        u_ctl_b.pick(1'b0);
        wait_cyc(4);
        check({busy_b, drive_b, reserved_b}, 3'h4);
        u_ctl_a.drop();
        pulse_check(10);
        wait_cyc(2);
        check({reserved_b, drive_b, drive_a}, 3'h6);
        u_ctl_b.drop();
        pulse_check(10);
    endtask : t_grant

    task automatic t_simul();
        fork
            u_ctl_a.pick(1'b0);
            u_ctl_b.pick(1'b0);
        join
        wait_cyc(2);
        check({reserved_a, busy_b, reserved_b}, 3'h6);
        fork
            u_ctl_a.drop();
            u_ctl_b.drop();
        join
        pulse_check(10);
    endtask : t_simul

    task automatic t_timer();
        timer_enable = 1'b1;
        u_ctl_a.pick(1'b0);
        u_ctl_a.drop();
        wait_cyc(RLEN / 2);
        check({reserved_a, drive_a, seek_end}, 3'h4);
        u_ctl_a.pick(1'b0);
        u_ctl_a.drop();
        wait_cyc(RLEN / 2);
        check({reserved_a, seek_end}, 2'h2);
        pulse_check(RLEN + 10);
        timer_enable = 1'b0;
    endtask : t_timer

    task automatic t_prio();
        u_ctl_a.pick(1'b1);
        check({priority_held, reserved_a}, 2'h3);
        timer_enable = 1'b1;
        u_ctl_a.drop();
        wait_cyc(RLEN + 20);
        check({reserved_a, seek_end}, 2'h2);
        u_ctl_b.pick(1'b1);
        check({reserved_b, busy_b, reserved_a}, 3'h3);
        u_ctl_b.drop();
        fork
            u_ctl_a.release_cmd();
            pulse_check(20);
        join
        check({reserved_a, priority_held}, 2'h0);
        timer_enable = 1'b0;
    endtask : t_prio

    task automatic t_power();
        u_ctl_a.pick(1'b0);
        power_seq = 1'b1;
        wait_cyc(4);
        check({reserved_a, drive_a, seek_end}, 3'h0);
        u_ctl_a.drop();
        power_seq = 1'b0;
        wait_cyc(6);
        check({reserved_a, reserved_b, seek_end}, 3'h0);
    endtask : t_power

    task automatic t_disable();
        enable_b = 1'b0;
        u_ctl_b.pick(1'b0);
        check({reserved_b, drive_b, busy_b}, 3'h0);
        u_ctl_a.pick(1'b0);
        check({reserved_a, busy_b}, 2'h2);
        u_ctl_b.drop();
        u_ctl_a.drop();
        pulse_check(10);
        enable_b = 1'b1;
    endtask : t_disable

    task automatic t_port_b();
        u_ctl_b.pick(1'b1);
        u_ctl_a.pick(1'b0);
        check({reserved_b, priority_held, busy_a, reserved_a}, 4'hE);
        enable_a = 1'b0;
        wait_cyc(4);
        check({busy_a, drive_a, reserved_b}, 3'h1);
        u_ctl_a.drop();
        fork
            u_ctl_b.release_cmd();
            pulse_check(20);
        join
        check({reserved_b, priority_held}, 2'h0);
        enable_a = 1'b1;
    endtask : t_port_b

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst         = 1'b0;
        enable_a     = 1'b1;
        enable_b     = 1'b1;
        timer_enable = 1'b0;
        power_seq    = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        nrst = 1'b1;
        wait_cyc(2);
        t_grant();
        t_simul();
        t_timer();
        t_prio();
        t_power();
        t_disable();
        t_port_b();
        end_sim();
    end

endmodule : dual_port_drive_reservation_tb
